// >>> phy_mgmt_cfg.svh
`ifndef PHY_MGMT_CFG_SVH
`define PHY_MGMT_CFG_SVH

// ==========================================================================
// Frame layout.
`define PM_PREAMBLE_LEN 6'h20
`define PM_HDR_BITS     6'h0C
`define PM_DATA_BITS    6'h10
`define PM_SKIP_BITS    6'h12
`define PM_TA_LAST      6'h01
`define PM_OP_READ      2'h2
`define PM_OP_WRITE     2'h1
`define PM_PHYAD_MIN    5'h01
`define PM_PHYAD_MAX    5'h05

// ==========================================================================
// Register addresses.
`define PM_REG_CTRL     5'h00
`define PM_REG_LAST_STD 5'h05
`define PM_REG_VEND_A   5'h1D
`define PM_REG_VEND_B   5'h1F

// ==========================================================================
// Control register fields and reset value.
`define PM_CTRL_RST     16'h3020
`define PM_B_SOFT_RST   15
`define PM_B_LOOP       14
`define PM_B_SPEED      13
`define PM_B_AN_ON      12
`define PM_B_PDOWN      11
`define PM_B_DETACH     10
`define PM_B_AN_KICK    9
`define PM_B_FDX        8
`define PM_B_XVAR       5
`define PM_B_STRAIGHT   4

`endif

// >>> phy_mgmt_pkg.sv
package phy_mgmt_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_HDR,
        ST_TA,
        ST_DATA,
        ST_SKIP
    } mdio_state_t;

endpackage

// >>> phy_ctrl_port.sv
`include "phy_mgmt_cfg.svh"

module phy_ctrl_port (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Register write and read.
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] ctrl_word,
    // Control outputs.
    output logic             soft_reset_pulse,
    output logic             mac_loopback,
    output logic             speed_100,
    output logic             autoneg_on,
    output logic             power_down,
    output logic             phy_detach,
    output logic             autoneg_kick,
    output logic             full_duplex,
    output logic             crossover_variant_select,
    output logic             straight_pair_force,
    // MAC to PHY boundary.
    input  wire logic        egress_en,
    input  wire logic [3:0]  egress_d,
    input  wire logic        phy_rx_dv,
    input  wire logic [3:0]  phy_rx_d,
    output logic             ingress_dv,
    output logic      [3:0]  ingress_d,
    output logic             line_tx_en,
    output logic      [3:0]  line_tx_d
);

    typedef struct packed {
        logic       srst;
        logic       loop;
        logic       spd;
        logic       an;
        logic       pd;
        logic       det;
        logic       kick;
        logic       fdx;
        logic       xvar;
        logic       strt;
        logic       idv;
        logic [3:0] id;
        logic       ten;
        logic [3:0] td;
    } port_st_t;

    port_st_t s_r;
    port_st_t s_nxt;
    logic [15:0] rst_v;

    assign rst_v = `PM_CTRL_RST;

    // ======================================================================
    // Field update and data path.
    always_comb begin
        s_nxt      = s_r;
        s_nxt.srst = 1'b0;
        s_nxt.kick = 1'b0;
        if (wr_en) begin
            // R4 soft reset pulse
            if (wr_data[`PM_B_SOFT_RST]) begin
                s_nxt.srst = 1'b1;
                s_nxt.loop = rst_v[`PM_B_LOOP];
                s_nxt.spd  = rst_v[`PM_B_SPEED];
                s_nxt.an   = rst_v[`PM_B_AN_ON];
                s_nxt.pd   = rst_v[`PM_B_PDOWN];
                s_nxt.det  = rst_v[`PM_B_DETACH];
                s_nxt.fdx  = rst_v[`PM_B_FDX];
                s_nxt.xvar = rst_v[`PM_B_XVAR];
                s_nxt.strt = rst_v[`PM_B_STRAIGHT];
            end else begin
                // R5 loopback bit store
                s_nxt.loop = wr_data[`PM_B_LOOP];
                // R8 speed force
                s_nxt.spd  = wr_data[`PM_B_SPEED];
                // R9 autoneg enable
                s_nxt.an   = wr_data[`PM_B_AN_ON];
                // R10 power down
                s_nxt.pd   = wr_data[`PM_B_PDOWN];
                // R11 isolate store
                s_nxt.det  = wr_data[`PM_B_DETACH];
                // R12 autoneg restart pulse
                s_nxt.kick = wr_data[`PM_B_AN_KICK];
                // R13 duplex force
                s_nxt.fdx  = wr_data[`PM_B_FDX];
                // R14 crossover variant
                s_nxt.xvar = wr_data[`PM_B_XVAR];
                // R15 straight pair force
                s_nxt.strt = wr_data[`PM_B_STRAIGHT];
            end
        end
        // R6 loopback turnaround path
        s_nxt.idv = s_r.loop ? egress_en : phy_rx_dv;
        s_nxt.id  = s_r.loop ? egress_d : phy_rx_d;
        // R11 transmit pair isolation
        s_nxt.ten = egress_en & ~s_r.loop & ~s_r.pd & ~s_r.det;
        s_nxt.td  = s_nxt.ten ? egress_d : 4'h0;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r      <= '0;
            s_r.loop <= rst_v[`PM_B_LOOP];
            s_r.spd  <= rst_v[`PM_B_SPEED];
            s_r.an   <= rst_v[`PM_B_AN_ON];
            s_r.pd   <= rst_v[`PM_B_PDOWN];
            s_r.det  <= rst_v[`PM_B_DETACH];
            s_r.fdx  <= rst_v[`PM_B_FDX];
            s_r.xvar <= rst_v[`PM_B_XVAR];
            s_r.strt <= rst_v[`PM_B_STRAIGHT];
        end else begin
            s_r <= s_nxt;
        end
    end

    // R16 read-only zero bits
    assign ctrl_word = {1'b0, s_r.loop, s_r.spd, s_r.an, s_r.pd, s_r.det, 1'b0,
                        s_r.fdx, 2'h0, s_r.xvar, s_r.strt, 4'h0};

    assign soft_reset_pulse         = s_r.srst;
    assign mac_loopback             = s_r.loop;
    assign speed_100                = s_r.spd;
    assign autoneg_on               = s_r.an;
    assign power_down               = s_r.pd;
    assign phy_detach               = s_r.det;
    assign autoneg_kick             = s_r.kick;
    assign full_duplex              = s_r.fdx;
    assign crossover_variant_select = s_r.xvar;
    assign straight_pair_force      = s_r.strt;
    assign ingress_dv               = s_r.idv;
    assign ingress_d                = s_r.id;
    assign line_tx_en               = s_r.ten;
    assign line_tx_d                = s_r.td;

    // ======================================================================
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_soft_reset_defaults: assert property ( // R4
        wr_en && wr_data[`PM_B_SOFT_RST] |=> soft_reset_pulse && speed_100 && autoneg_on
        && !mac_loopback && ctrl_word[`PM_B_SOFT_RST] == 1'b0)
        else $error("Soft reset did not pulse or restore defaults.");
    a_loop_store: assert property ( // R5
        wr_en && !wr_data[`PM_B_SOFT_RST] |=> mac_loopback == $past(wr_data[`PM_B_LOOP])
        && full_duplex == $past(wr_data[`PM_B_FDX]))
        else $error("Control write not stored.");
    a_kick_pulse: assert property ( // R12
        wr_en && !wr_data[`PM_B_SOFT_RST] && wr_data[`PM_B_AN_KICK]
        |=> autoneg_kick && !ctrl_word[`PM_B_AN_KICK])
        else $error("Autoneg restart did not pulse.");
    a_loop_turn: assert property ( // R6
        mac_loopback && egress_en |=> ingress_dv && ingress_d == $past(egress_d) && !line_tx_en)
        else $error("Loopback did not turn traffic around.");
    a_detach_quiet: assert property ( // R11
        phy_detach || power_down |=> !line_tx_en)
        else $error("Transmit pair driven while isolated.");
    a_ro_bits: assert property ( // R16
        ctrl_word[7:6] == 2'h0)
        else $error("Read-only control bits not zero.");
    c_loopback: cover property (mac_loopback && egress_en);
    c_soft_reset: cover property (soft_reset_pulse);

endmodule // phy_ctrl_port

// >>> phy_mgmt_control_register.sv
// Contract
// R1 - Frames with a PHY address of 1 to 5 are answered, each selecting the port of that number.
// R2 - Register addresses 0 to 5, 0x1D and 0x1F are served per port; others get no answer.
// R3 - Every port register is also reachable through the host port with its own mapping.
// R4 - Writing one to control bit 15 soft-resets the port PHY and the bit reads back zero.
// R5 - Control bit 14 enables MAC loopback for its port, resetting to zero.
// R6 - In loopback, switch egress for the port is turned back at the MAC/PHY boundary.
// R7 - The loopback bit of ports 3, 4 and 5 loops those ports in the same way.
// R8 - Control bit 13 forces 100 Mbps when set and 10 Mbps when clear, resetting to one.
// R9 - Control bit 12 enables auto-negotiation, resetting to one.
// R10 - Control bit 11 powers the port PHY down, resetting to zero.
// R11 - Control bit 10 isolates the PHY from its transmit pair, resetting to zero.
// R12 - Writing one to control bit 9 restarts auto-negotiation and the bit reads zero.
// R13 - Control bit 8 forces full duplex when set, resetting to zero.
// R14 - Control bit 5 selects between two crossover algorithms, resetting to one.
// R15 - Control bit 4 forces straight-through pairs when set, resetting to zero.
// R16 - Control bits 7 and 6 read zero and ignore writes.
`include "phy_mgmt_cfg.svh"

module phy_mgmt_control_register #(
    parameter int NPORTS = 5
) (
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // Management serial pins.
    input  wire logic                mdc,
    input  wire logic                mdio_in,
    output logic                     mdio_out,
    output logic                     mdio_oe,
    // Host port.
    input  wire logic                host_req,
    input  wire logic                host_we,
    input  wire logic [2:0]          host_port,
    input  wire logic [4:0]          host_reg,
    input  wire logic [15:0]         host_wdata,
    output logic                     host_ack,
    output logic      [15:0]         host_rdata,
    // Per-port controls.
    output logic      [NPORTS-1:0]   soft_reset_pulse,
    output logic      [NPORTS-1:0]   mac_loopback,
    output logic      [NPORTS-1:0]   speed_100,
    output logic      [NPORTS-1:0]   autoneg_on,
    output logic      [NPORTS-1:0]   power_down,
    output logic      [NPORTS-1:0]   phy_detach,
    output logic      [NPORTS-1:0]   autoneg_kick,
    output logic      [NPORTS-1:0]   full_duplex,
    output logic      [NPORTS-1:0]   crossover_variant_select,
    output logic      [NPORTS-1:0]   straight_pair_force,
    // Per-port MAC/PHY boundary.
    input  wire logic [NPORTS-1:0]   egress_en,
    input  wire logic [4*NPORTS-1:0] egress_d,
    input  wire logic [NPORTS-1:0]   phy_rx_dv,
    input  wire logic [4*NPORTS-1:0] phy_rx_d,
    output logic      [NPORTS-1:0]   ingress_dv,
    output logic      [4*NPORTS-1:0] ingress_d,
    output logic      [NPORTS-1:0]   line_tx_en,
    output logic      [4*NPORTS-1:0] line_tx_d
);

    typedef struct packed {
        phy_mgmt_pkg::mdio_state_t st;
        logic [5:0]                cnt;
        logic [15:0]               sh;
        logic                      rd;
        logic [4:0]                phy;
        logic [4:0]                rga;
        logic                      mdc_q;
        logic                      mo;
        logic                      moe;
        logic [NPORTS-1:0]         wr_en;
        logic [15:0]               wr_data;
        logic                      hack;
        logic [15:0]               hrd;
    } mgmt_st_t;

    mgmt_st_t          s_r;
    mgmt_st_t          s_nxt;
    logic [15:0]       ctrl_word [NPORTS];
    logic              mdc_rise;

    function automatic logic reg_ok(input logic [4:0] a);
        return (a <= `PM_REG_LAST_STD) || (a == `PM_REG_VEND_A) || (a == `PM_REG_VEND_B);
    endfunction

    function automatic logic phy_ok(input logic [4:0] a);
        return (a >= `PM_PHYAD_MIN) && (a <= `PM_PHYAD_MAX);
    endfunction

    assign mdc_rise = mdc & ~s_r.mdc_q;

    // ======================================================================
    // Frame engine and host access.
    always_comb begin
        logic [4:0] p;
        logic [4:0] r;
        logic [1:0] op;
        p          = 5'h00;
        r          = 5'h00;
        op         = 2'h0;
        s_nxt      = s_r;
        s_nxt.mdc_q = mdc;
        s_nxt.wr_en = '0;
        s_nxt.hack = 1'b0;
        if (mdc_rise) begin
            unique case (s_r.st)
                phy_mgmt_pkg::ST_IDLE: begin
                    if (mdio_in) begin
                        if (s_r.cnt != `PM_PREAMBLE_LEN) s_nxt.cnt = s_r.cnt + 6'h01;
                    end else begin
                        s_nxt.st  = (s_r.cnt == `PM_PREAMBLE_LEN) ? phy_mgmt_pkg::ST_START
                                                                  : phy_mgmt_pkg::ST_IDLE;
                        s_nxt.cnt = 6'h00;
                    end
                end
                phy_mgmt_pkg::ST_START: begin
                    s_nxt.st  = mdio_in ? phy_mgmt_pkg::ST_HDR : phy_mgmt_pkg::ST_IDLE;
                    s_nxt.cnt = 6'h00;
                end
                phy_mgmt_pkg::ST_HDR: begin
                    s_nxt.sh  = {s_r.sh[14:0], mdio_in};
                    s_nxt.cnt = s_r.cnt + 6'h01;
                    if (s_nxt.cnt == `PM_HDR_BITS) begin
                        op = s_nxt.sh[11:10];
                        p  = s_nxt.sh[9:5];
                        r  = s_nxt.sh[4:0];
                        s_nxt.phy = p;
                        s_nxt.rga = r;
                        s_nxt.rd  = (op == `PM_OP_READ);
                        s_nxt.cnt = 6'h00;
                        s_nxt.st  = phy_mgmt_pkg::ST_SKIP;
                        // R1 address decode
                        // R2 register decode
                        if (phy_ok(p) && reg_ok(r) &&
                            (op == `PM_OP_READ || op == `PM_OP_WRITE)) begin
                            s_nxt.st = phy_mgmt_pkg::ST_TA;
                            s_nxt.sh = 16'h0000;
                            if (r == `PM_REG_CTRL) s_nxt.sh = ctrl_word[3'(p - `PM_PHYAD_MIN)];
                        end
                    end
                end
                phy_mgmt_pkg::ST_TA: begin
                    s_nxt.cnt = s_r.cnt + 6'h01;
                    if (s_r.rd) begin
                        s_nxt.moe = 1'b1;
                        s_nxt.mo  = 1'b0;
                        s_nxt.cnt = 6'h00;
                        s_nxt.st  = phy_mgmt_pkg::ST_DATA;
                    end else if (s_r.cnt == `PM_TA_LAST) begin
                        s_nxt.cnt = 6'h00;
                        s_nxt.st  = phy_mgmt_pkg::ST_DATA;
                    end
                end
                phy_mgmt_pkg::ST_DATA: begin
                    s_nxt.cnt = s_r.cnt + 6'h01;
                    if (s_r.rd) begin
                        s_nxt.mo = s_r.sh[15];
                        s_nxt.sh = {s_r.sh[14:0], 1'b0};
                        if (s_r.cnt == `PM_DATA_BITS) begin
                            s_nxt.moe = 1'b0;
                            s_nxt.mo  = 1'b0;
                            s_nxt.cnt = 6'h00;
                            s_nxt.st  = phy_mgmt_pkg::ST_IDLE;
                        end
                    end else begin
                        s_nxt.sh = {s_r.sh[14:0], mdio_in};
                        if (s_nxt.cnt == `PM_DATA_BITS) begin
                            // R7 per-port write select
                            if (s_r.rga == `PM_REG_CTRL)
                                s_nxt.wr_en[3'(s_r.phy - `PM_PHYAD_MIN)] = 1'b1;
                            s_nxt.wr_data = s_nxt.sh;
                            s_nxt.cnt     = 6'h00;
                            s_nxt.st      = phy_mgmt_pkg::ST_IDLE;
                        end
                    end
                end
                phy_mgmt_pkg::ST_SKIP: begin
                    s_nxt.cnt = s_r.cnt + 6'h01;
                    if (s_nxt.cnt == `PM_SKIP_BITS) begin
                        s_nxt.cnt = 6'h00;
                        s_nxt.st  = phy_mgmt_pkg::ST_IDLE;
                    end
                end
            endcase
        end
        // R3 host port access
        if (host_req && !s_r.hack && s_nxt.wr_en == '0) begin
            s_nxt.hack = 1'b1;
            s_nxt.hrd  = 16'h0000;
            if (host_port < 3'(NPORTS) && host_reg == `PM_REG_CTRL) begin
                s_nxt.hrd = ctrl_word[host_port];
                if (host_we) begin
                    s_nxt.wr_en[host_port] = 1'b1;
                    s_nxt.wr_data          = host_wdata;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r    <= '0;
            s_r.st <= phy_mgmt_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign mdio_out   = s_r.mo;
    assign mdio_oe    = s_r.moe;
    assign host_ack   = s_r.hack;
    assign host_rdata = s_r.hrd;

    // ======================================================================
    // Port control registers.
    for (genvar i = 0; i < NPORTS; i++) begin : g_port
        phy_ctrl_port u_port (
            .clk                      (clk),
            .sys_rst                  (sys_rst),
            .wr_en                    (s_r.wr_en[i]),
            .wr_data                  (s_r.wr_data),
            .ctrl_word                (ctrl_word[i]),
            .soft_reset_pulse         (soft_reset_pulse[i]),
            .mac_loopback             (mac_loopback[i]),
            .speed_100                (speed_100[i]),
            .autoneg_on               (autoneg_on[i]),
            .power_down               (power_down[i]),
            .phy_detach               (phy_detach[i]),
            .autoneg_kick             (autoneg_kick[i]),
            .full_duplex              (full_duplex[i]),
            .crossover_variant_select (crossover_variant_select[i]),
            .straight_pair_force      (straight_pair_force[i]),
            .egress_en                (egress_en[i]),
            .egress_d                 (egress_d[4*i +: 4]),
            .phy_rx_dv                (phy_rx_dv[i]),
            .phy_rx_d                 (phy_rx_d[4*i +: 4]),
            .ingress_dv               (ingress_dv[i]),
            .ingress_d                (ingress_d[4*i +: 4]),
            .line_tx_en               (line_tx_en[i]),
            .line_tx_d                (line_tx_d[4*i +: 4])
        );
    end

    // ======================================================================
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_phy_answer: assert property ( // R1
        $rose(mdio_oe) |-> phy_ok(s_r.phy) && s_r.rd)
        else $error("Answered a frame for a foreign PHY address.");
    a_reg_answer: assert property ( // R2
        $rose(mdio_oe) |-> reg_ok(s_r.rga) && !mdio_out)
        else $error("Answered an unsupported register or bad turnaround.");
    a_write_route: assert property ( // R7
        s_r.wr_en != '0 |-> $onehot(s_r.wr_en))
        else $error("Write reached more than one port.");
    a_host_ack: assert property ( // R3
        host_req && !host_ack && s_nxt.wr_en == '0 |=> host_ack ##1 !host_ack)
        else $error("Host access not acknowledged in one cycle.");
    c_mdio_read: cover property ($rose(mdio_oe));
    c_host_write: cover property (host_req && host_we && host_ack);

endmodule // phy_mgmt_control_register

// >>> mdio_station.sv
// ==========================================================================
// Station manager model: makes the management clock only within frames.
module mdio_station (
    // Clock.
    input  wire logic clk,
    // Management wire.
    output logic      mdc,
    output logic      sta_oe,
    output logic      sta_d,
    input  wire logic mdio_wire
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        mdc = 1'b0;
        sta_oe = 1'b0;
        sta_d = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Sets the data in the low phase, then raises the clock.
    task automatic put_bit(input logic b);
        sta_oe = 1'b1;
        sta_d = b;
        wait_clk(4);
        mdc = 1'b1;
        wait_clk(4);
        mdc = 1'b0;
    endtask

    // Releases the wire and samples it just before the rising edge.
    task automatic get_bit(output logic b);
        sta_oe = 1'b0;
        wait_clk(4);
        b = mdio_wire;
        mdc = 1'b1;
        wait_clk(4);
        mdc = 1'b0;
    endtask

    // Runs one frame; a read returns the second turnaround bit and the word.
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic ta, output logic [15:0] rdw);
        logic [13:0] hdr;
        logic        spare;
        hdr = {2'h1, (rd ? 2'h2 : 2'h1), phy, rg};
        rdw = 16'h0000;
        ta = 1'b1;
        for (int i = 0; i < 32; i++) put_bit(1'b1);
        for (int i = 13; i >= 0; i--) put_bit(hdr[i]);
        if (rd) begin
            get_bit(ta);
            get_bit(ta);
            for (int i = 15; i >= 0; i--) get_bit(rdw[i]);
            get_bit(spare);
        end else begin
            put_bit(1'b1);
            put_bit(1'b0);
            for (int i = 15; i >= 0; i--) put_bit(wd[i]);
            sta_oe = 1'b0;
        end
    endtask
endmodule // mdio_station

// >>> tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk, sys_rst, mdc, mdio_out, mdio_oe, sta_oe, sta_d, mdio_wire, ta;
    logic        host_req, host_we, host_ack;
    logic [2:0]  host_port;
    logic [4:0]  host_reg, srst, loop, spd, an, pdn, det, kick, fdx, xvar, strt;
    logic [4:0]  egress_en, phy_rx_dv, ingress_dv, line_tx_en, kick_seen, srst_seen;
    logic [15:0] host_wdata, host_rdata, rdw;
    logic [19:0] egress_d, phy_rx_d, ingress_d, line_tx_d;
    int          bad_count, check_count;

    // Wire with pull-up: device, then station, else high.
    assign mdio_wire = mdio_oe ? mdio_out : (sta_oe ? sta_d : 1'b1);

    phy_mgmt_control_register #(.NPORTS(5)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_wire),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .host_req(host_req), .host_we(host_we),
        .host_port(host_port), .host_reg(host_reg), .host_wdata(host_wdata),
        .host_ack(host_ack), .host_rdata(host_rdata), .soft_reset_pulse(srst),
        .mac_loopback(loop), .speed_100(spd), .autoneg_on(an), .power_down(pdn),
        .phy_detach(det), .autoneg_kick(kick), .full_duplex(fdx),
        .crossover_variant_select(xvar), .straight_pair_force(strt),
        .egress_en(egress_en), .egress_d(egress_d), .phy_rx_dv(phy_rx_dv),
        .phy_rx_d(phy_rx_d), .ingress_dv(ingress_dv), .ingress_d(ingress_d),
        .line_tx_en(line_tx_en), .line_tx_d(line_tx_d));

    mdio_station u_sta (.clk(clk), .mdc(mdc), .sta_oe(sta_oe), .sta_d(sta_d),
                        .mdio_wire(mdio_wire));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Host access: holds the request through the edge that sees the ack.
    task automatic host(input logic we, input logic [2:0] p, input logic [15:0] wd,
                        output logic [15:0] rd);
        int n;
        n = 0;
        host_req = 1'b1;
        host_we = we;
        host_port = p;
        host_reg = 5'h00;
        host_wdata = wd;
        tick();
        while (host_ack !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        check(host_ack, 20'h00001);
        rd = host_rdata;
        tick();
        kick_seen = kick;
        srst_seen = srst;
        host_req = 1'b0;
        tick();
    endtask

    task automatic t_reset();
        for (int p = 0; p < 5; p++) begin
            host(1'b0, p[2:0], 16'h0000, rdw);
            check(rdw, 20'h03020);
        end
        check(spd, 20'h1F);
        check(an, 20'h1F);
        check(xvar, 20'h1F);
        check(loop | pdn | det | fdx | strt, 20'h0);
    endtask

    task automatic t_mdio_read();
        logic [4:0] regs [4] = '{5'h01, 5'h05, 5'h1D, 5'h1F};
        logic [9:0] miss [3] = '{10'h000, 10'h0C0, 10'h046};
        for (int p = 1; p < 6; p++) begin
            u_sta.frame(1'b1, p[4:0], 5'h00, 16'h0000, ta, rdw);
            check({ta, rdw}, 20'h03020);
        end
        for (int i = 0; i < 4; i++) begin
            u_sta.frame(1'b1, 5'h03, regs[i], 16'h0000, ta, rdw);
            check({ta, rdw}, 20'h00000);
        end
        for (int i = 0; i < 3; i++) begin
            u_sta.frame(1'b1, miss[i][9:5], miss[i][4:0], 16'h0000, ta, rdw);
            check({ta, rdw}, 20'h1FFFF);
        end
    endtask

    task automatic t_mdio_write();
        u_sta.frame(1'b0, 5'h02, 5'h00, 16'h4DD0, ta, rdw);
        check(loop, 20'h02);
        check(spd, 20'h1D);
        check(an, 20'h1D);
        check(pdn, 20'h02);
        check(det, 20'h02);
        check(fdx, 20'h02);
        check(xvar, 20'h1D);
        check(strt, 20'h02);
        host(1'b0, 3'h1, 16'h0000, rdw);
        check(rdw, 20'h04D10);
        u_sta.frame(1'b1, 5'h02, 5'h00, 16'h0000, ta, rdw);
        check({ta, rdw}, 20'h04D10);
    endtask

    task automatic t_pulses();
        host(1'b1, 3'h0, 16'h0200, rdw);
        check(kick_seen, 20'h01);
        host(1'b0, 3'h0, 16'h0000, rdw);
        check(rdw, 20'h00000);
        host(1'b1, 3'h0, 16'h8000, rdw);
        check(srst_seen, 20'h01);
        host(1'b0, 3'h0, 16'h0000, rdw);
        check(rdw, 20'h03020);
        host(1'b0, 3'h5, 16'h0000, rdw);
        check(rdw, 20'h00000);
    endtask

    task automatic t_loop();
        for (int p = 2; p < 5; p++) host(1'b1, p[2:0], 16'h7020, rdw);
        egress_en = 5'h1F;
        egress_d = 20'h54321;
        phy_rx_dv = 5'h1F;
        phy_rx_d = 20'hABCDE;
        tick();
        tick();
        check(ingress_dv, 20'h1F);
        check(ingress_d, 20'h5432E);
        check({line_tx_en, line_tx_d[14:0]}, 20'h08001);
        host(1'b1, 3'h2, 16'h3020, rdw);
        tick();
        check(ingress_d, 20'h54C2E);
        check({line_tx_en, line_tx_d[14:0]}, 20'h28301);
    endtask

    initial begin
        sys_rst = 1'b1;
        {host_req, host_we, host_port, host_reg, host_wdata} = '0;
        {egress_en, egress_d, phy_rx_dv, phy_rx_d} = '0;
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_mdio_read();
        t_mdio_write();
        t_pulses();
        t_loop();
        end_of_test();
    end

    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end
endmodule // tb_top
